// ---- rtl/srel_pkg.sv ----
// package: register map, field layout, codes and carriers of the standby-release config block
package srel_pkg;

   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 32;
   // register offsets (byte addresses)
   localparam logic [7:0]  OFF_MODE_CTRL   = 8'h00;
   localparam logic [7:0]  OFF_IRQ_CLEAR   = 8'h04;
   localparam logic [7:0]  OFF_IRQ_STATUS  = 8'h08;
   localparam logic [7:0]  OFF_IRQ_MASK    = 8'h0C;
   // field positions in the mode control register
   localparam int          CH0_EN_BIT      = 0;
   localparam int          CH0_UNDEF_BIT   = 1;
   localparam int          CH0_REPORT_LSB  = 2;
   localparam int          CH0_SELECT_LSB  = 4;
   localparam int          CH1_EN_BIT      = 8;
   localparam int          CH1_UNDEF_BIT   = 9;
   localparam int          CH1_REPORT_LSB  = 10;
   localparam int          CH1_SELECT_LSB  = 12;
   localparam int          CH2_EN_BIT      = 16;
   localparam int          CH2_UNDEF_BIT   = 17;
   // irq status / clear / mask bit positions
   localparam int          IRQ_CH0_BIT     = 0;
   localparam int          IRQ_CH1_BIT     = 1;
   localparam int          IRQ_CH2_BIT     = 2;
   // reset values
   localparam logic [2:0]  SELECT_RESET    = 3'h2;
   localparam logic [1:0]  REPORT_RESET    = 2'h0;
   localparam logic        ENABLE_RESET    = 1'b0;
   localparam logic [2:0]  MASK_RESET      = 3'h0;
   // value returned on the bits that read as undefined
   localparam logic        UNDEF_READ      = 1'b0;
   // edge report codes
   localparam logic [1:0]  REPORT_NONE     = 2'h0;
   localparam logic [1:0]  REPORT_RISE     = 2'h1;
   localparam logic [1:0]  REPORT_FALL     = 2'h2;
   localparam logic [1:0]  REPORT_BOTH     = 2'h3;

   typedef enum logic [2:0] {
      TRIG_LOW  = 3'h0,
      TRIG_HIGH = 3'h1,
      TRIG_FALL = 3'h2,
      TRIG_RISE = 3'h3,
      TRIG_BOTH = 3'h4
   } trigger_t;

   // register bus request
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } bus_req_t;

   // per-channel configuration handed to the detector
   typedef struct packed {
      logic [2:0] trigger_select;
      logic       release_enable;
   } chan_cfg_t;

endpackage

// ---- rtl/srel_detect.sv ----
// one channel: level/edge detector producing a standby-release request and edge events
module srel_detect
   import srel_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire chan_cfg_t  cfg,
   input  wire logic       pin,
   output logic            request,
   output logic            rise,
   output logic            fall
);

   typedef struct packed {
      logic prev;
      logic primed;
   } det_state_t;

   det_state_t s_q;
   det_state_t s_d;

   always_comb begin
      s_d        = s_q;
      s_d.prev   = pin;
      s_d.primed = 1'b1;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // no edge reported until one previous sample exists
   assign rise = s_q.primed & pin & ~s_q.prev;
   assign fall = s_q.primed & ~pin & s_q.prev;

   always_comb begin
      request = 1'b0;
      if (cfg.release_enable) begin
         unique case (cfg.trigger_select)
            TRIG_LOW:  request = ~pin;
            TRIG_HIGH: request = pin;
            TRIG_FALL: request = fall;
            TRIG_RISE: request = rise;
            TRIG_BOTH: request = rise | fall;
            // prohibited codes: no request
            default:   request = 1'b0;
         endcase
      end
   end

endmodule

// ---- rtl/standby_release_trigger_config.sv ----
// top: standby-release mode control register, edge report, irq status/mask for ext request channels
// What this block does
// - ch1 trigger select bits 14-12 picks condition
// - ch1 edge report bits 11-10 shows edge
// - bit 8 enables ch1 release input
// - ch0 trigger select bits 6-4, same coding
// - ch0 edge report bits 3-2 encodes edge
// - bit 0 enables ch0 release input
// - edge report updates only in both-edge mode
// - irq clear also zeroes the edge report
// - bit 16 enables ch2 release input
//
// Added by the designer: the address-and-strobe port and the address map.
module standby_release_trigger_config
   import srel_pkg::*;
#(
   parameter int NUM_CH = 3
)
(
   input  wire logic              CLK_SYS,
   input  wire logic              RSTN,
   input  wire logic [ADDR_W-1:0] ADDR,
   input  wire logic [DATA_W-1:0] WDATA,
   input  wire logic              WR,
   input  wire logic              RD,
   output logic [DATA_W-1:0]      RDATA,
   input  wire logic              EXT_REQUEST_CH0,
   input  wire logic              EXT_REQUEST_CH1,
   input  wire logic              EXT_REQUEST_CH2,
   output logic [NUM_CH-1:0]      RELEASE_REQ,
   output logic                   IRQ
);

   typedef struct packed {
      logic [2:0]        ch0_trigger_select;
      logic [1:0]        ch0_edge_report;
      logic              ch0_release_enable;
      logic [2:0]        ch1_trigger_select;
      logic [1:0]        ch1_edge_report;
      logic              ch1_release_enable;
      logic              ch2_release_enable;
      logic [NUM_CH-1:0] irq_status;
      logic [NUM_CH-1:0] irq_mask;
      logic [NUM_CH-1:0] release_req;
      logic              irq;
      logic [DATA_W-1:0] rdata;
   } state_t;

   state_t              st_q;
   state_t              st_d;
   bus_req_t            req;
   chan_cfg_t           cfg [NUM_CH];
   logic [NUM_CH-1:0]   pins;
   logic [NUM_CH-1:0]   det_req;
   logic [NUM_CH-1:0]   det_rise;
   logic [NUM_CH-1:0]   det_fall;

   assign req  = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
   assign pins = {EXT_REQUEST_CH2, EXT_REQUEST_CH1, EXT_REQUEST_CH0};

   assign cfg[1] = '{trigger_select: st_q.ch1_trigger_select, release_enable: st_q.ch1_release_enable};
   assign cfg[0] = '{trigger_select: st_q.ch0_trigger_select, release_enable: st_q.ch0_release_enable};
   // ch2 select sits in the next register, so ch2 is fixed to falling edge here
   assign cfg[2] = '{trigger_select: SELECT_RESET, release_enable: st_q.ch2_release_enable};

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         srel_detect u_det (
            .clk     (CLK_SYS),
            .rst_n   (RSTN),
            .cfg     (cfg[g]),
            .pin     (pins[g]),
            .request (det_req[g]),
            .rise    (det_rise[g]),
            .fall    (det_fall[g])
         );
      end
   endgenerate

   // merges a new edge into a report, accumulating to both
   function automatic logic [1:0] merge_report(input logic [1:0] cur,
                                               input logic       r,
                                               input logic       f);
      logic [1:0] v;
      v = cur;
      if (r) begin
         v = v | REPORT_RISE;
      end
      if (f) begin
         v = v | REPORT_FALL;
      end
      return v;
   endfunction

   logic [DATA_W-1:0] mode_word;
   logic [NUM_CH-1:0] clr_bits;
   logic              wr_mode;
   logic              wr_clear;

   always_comb begin
      mode_word = '0;
      mode_word[CH1_EN_BIT]                       = st_q.ch1_release_enable;
      mode_word[CH0_EN_BIT]                       = st_q.ch0_release_enable;
      mode_word[CH2_EN_BIT]                       = st_q.ch2_release_enable;
      mode_word[CH1_SELECT_LSB +: 3]              = st_q.ch1_trigger_select;
      mode_word[CH0_SELECT_LSB +: 3]              = st_q.ch0_trigger_select;
      mode_word[CH1_REPORT_LSB +: 2]              = st_q.ch1_edge_report;
      mode_word[CH0_REPORT_LSB +: 2]              = st_q.ch0_edge_report;
      mode_word[CH0_UNDEF_BIT]                    = UNDEF_READ;
      mode_word[CH1_UNDEF_BIT]                    = UNDEF_READ;
      mode_word[CH2_UNDEF_BIT]                    = UNDEF_READ;
   end

   assign wr_mode  = req.wr && (req.addr == OFF_MODE_CTRL);
   assign wr_clear = req.wr && (req.addr == OFF_IRQ_CLEAR);
   assign clr_bits = wr_clear ? req.wdata[NUM_CH-1:0] : '0;

   always_comb begin
      st_d = st_q;

      // register writes; are left to software, codes stored as written
      if (wr_mode) begin
         st_d.ch0_release_enable = req.wdata[CH0_EN_BIT];
         st_d.ch1_release_enable = req.wdata[CH1_EN_BIT];
         st_d.ch2_release_enable = req.wdata[CH2_EN_BIT];
         st_d.ch0_trigger_select = req.wdata[CH0_SELECT_LSB +: 3];
         st_d.ch1_trigger_select = req.wdata[CH1_SELECT_LSB +: 3];
      end
      if (req.wr && (req.addr == OFF_IRQ_MASK)) begin
         st_d.irq_mask = req.wdata[NUM_CH-1:0];
      end

      if (clr_bits[IRQ_CH0_BIT]) begin
         st_d.ch0_edge_report = REPORT_NONE;
      end
      if (clr_bits[IRQ_CH1_BIT]) begin
         st_d.ch1_edge_report = REPORT_NONE;
      end

      // report only in both mode; a new edge beats a same-cycle clear
      if (st_q.ch0_trigger_select == TRIG_BOTH && st_q.ch0_release_enable &&
          (det_rise[0] || det_fall[0])) begin
         st_d.ch0_edge_report = merge_report(clr_bits[IRQ_CH0_BIT] ? REPORT_NONE : st_q.ch0_edge_report,
                                             det_rise[0], det_fall[0]);
      end
      if (st_q.ch1_trigger_select == TRIG_BOTH && st_q.ch1_release_enable &&
          (det_rise[1] || det_fall[1])) begin
         st_d.ch1_edge_report = merge_report(clr_bits[IRQ_CH1_BIT] ? REPORT_NONE : st_q.ch1_edge_report,
                                             det_rise[1], det_fall[1]);
      end

      // sticky status: set wins over write-one clear
      st_d.irq_status  = (st_q.irq_status & ~clr_bits) | det_req;
      st_d.release_req = det_req;
      st_d.irq         = |(st_d.irq_status & st_d.irq_mask);

      // read data valid only in the cycle after the strobe
      st_d.rdata = '0;
      if (req.rd) begin
         unique case (req.addr)
            OFF_MODE_CTRL:  st_d.rdata = mode_word;
            OFF_IRQ_STATUS: st_d.rdata = DATA_W'(st_q.irq_status);
            OFF_IRQ_MASK:   st_d.rdata = DATA_W'(st_q.irq_mask);
            // clear register and unmapped addresses read zero
            default:        st_d.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         st_q                    <= '0;
         st_q.ch0_trigger_select <= SELECT_RESET;
         st_q.ch1_trigger_select <= SELECT_RESET;
         st_q.ch0_edge_report    <= REPORT_RESET;
         st_q.ch1_edge_report    <= REPORT_RESET;
         st_q.ch0_release_enable <= ENABLE_RESET;
         st_q.ch1_release_enable <= ENABLE_RESET;
         st_q.ch2_release_enable <= ENABLE_RESET;
         st_q.irq_mask           <= MASK_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   assign RDATA       = st_q.rdata;
   assign RELEASE_REQ = st_q.release_req;
   assign IRQ         = st_q.irq;

endmodule

// ---- bench/ext_pins.sv ----
// partner: external request pins with an adjustable response lag
module ext_pins (
   input  wire logic       clk,
   input  wire logic [2:0] want,
   input  wire logic [3:0] lag,
   output logic      [2:0] pins
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] hist_q [16];
   // zero lag follows the bench at once, larger lags model a slow source
   assign pins = (lag == 4'h0) ? want : hist_q[lag - 4'h1];
   always_ff @(posedge clk) begin
      hist_q[0] <= want;
      for (int i = 1; i < 16; i++) hist_q[i] <= hist_q[i - 1];
   end
endmodule

// ---- bench/srel_assertions.sv ----
// checker: port-level assertions for the standby-release config block
module srel_assertions
   import srel_pkg::*;
#(
   parameter int NUM_CH = 3
)
(
   input wire logic              CLK_SYS,
   input wire logic              RSTN,
   input wire logic [ADDR_W-1:0] ADDR,
   input wire logic [DATA_W-1:0] WDATA,
   input wire logic              WR,
   input wire logic              RD,
   input wire logic [DATA_W-1:0] RDATA,
   input wire logic              EXT_REQUEST_CH0,
   input wire logic              EXT_REQUEST_CH1,
   input wire logic              EXT_REQUEST_CH2,
   input wire logic [NUM_CH-1:0] RELEASE_REQ,
   input wire logic              IRQ
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] sel0_q, sel1_q, en_q;
   wire        rdm = RD && ADDR == OFF_MODE_CTRL;
   // shadow of the mode word, so no internal probes are needed
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         sel0_q <= SELECT_RESET;
         sel1_q <= SELECT_RESET;
         en_q   <= 3'h0;
      end else if (WR && ADDR == OFF_MODE_CTRL) begin
         sel0_q <= WDATA[6:4];
         sel1_q <= WDATA[14:12];
         en_q   <= {WDATA[16], WDATA[8], WDATA[0]};
      end
   end
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RSTN);
   sequence s_pulse1; RELEASE_REQ[1] ##1 !RELEASE_REQ[1]; endsequence
   property p_ch1_rd; rdm |=> RDATA[14:12] == $past(sel1_q) && RDATA[8] == $past(en_q[1]); endproperty
   a_ch1_rd: assert property (p_ch1_rd) else $error("ch1 readback");
   property p_ch0_rd; rdm |=> RDATA[6:4] == $past(sel0_q) && RDATA[0] == $past(en_q[0]); endproperty
   a_ch0_rd: assert property (p_ch0_rd) else $error("ch0 readback");
   property p_ch2_rd; rdm |=> RDATA[16] == $past(en_q[2]); endproperty
   a_ch2_rd: assert property (p_ch2_rd) else $error("ch2 enable readback");
   property p_rsv; rdm |=> RDATA[31:17] == 15'h0 && RDATA[15] == 1'b0 && RDATA[7] == 1'b0; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
   property p_ch1_off; !en_q[1] |=> !RELEASE_REQ[1]; endproperty
   a_ch1_off: assert property (p_ch1_off) else $error("ch1 request while disabled");
   property p_ch1_high; en_q[1] && sel1_q == TRIG_HIGH && EXT_REQUEST_CH1 |=> RELEASE_REQ[1]; endproperty
   a_ch1_high: assert property (p_ch1_high) else $error("ch1 high level missed");
   property p_ch0_low; en_q[0] && sel0_q == TRIG_LOW && !EXT_REQUEST_CH0 |=> RELEASE_REQ[0]; endproperty
   a_ch0_low: assert property (p_ch0_low) else $error("ch0 low level missed");
   property p_ch1_both;
      en_q[1] && sel1_q == TRIG_BOTH && $rose(EXT_REQUEST_CH1) ##1 $stable(EXT_REQUEST_CH1) |-> s_pulse1;
   endproperty
   a_ch1_both: assert property (p_ch1_both) else $error("ch1 edge pulse wrong");
endmodule

// ---- bench/testbench.sv ----
// testbench: register and pin scenarios for the standby-release config block
module testbench import srel_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk_sys = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, irq;
   logic [7:0]  addr = 8'h0;
   logic [31:0] wdata = 32'h0, rdata;
   logic [2:0]  req, pins, want = 3'h1;
   logic [3:0]  lag = 4'h0;
   int          miscompares = 0, checks_done = 0;
   always #12.5 clk_sys = ~clk_sys;
   standby_release_trigger_config dut_u (.CLK_SYS(clk_sys), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .EXT_REQUEST_CH0(pins[0]), .EXT_REQUEST_CH1(pins[1]), .EXT_REQUEST_CH2(pins[2]),
      .RELEASE_REQ(req), .IRQ(irq));
   ext_pins pin_u (.clk(clk_sys), .want(want), .lag(lag), .pins(pins));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk_sys);
      wr    <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_sys);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk_sys);
      rd   <= 1'b0;
      #1 chk($sformatf("reg %h", a), exp, rdata);
   endtask
   task automatic close_out();
      if (miscompares == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wait_req(input int idx);
      repeat (20) if (req[idx] !== 1'b1) @(posedge clk_sys) #1;
      if (req[idx] !== 1'b1) begin
         miscompares++;
         close_out();
      end
   endtask
   initial begin
      repeat (20) @(posedge clk_sys);
      rstn <= 1'b1;
      rd_chk(OFF_MODE_CTRL, 32'h2020);
      wr_reg(OFF_MODE_CTRL, 32'hFFFE9ECE);
      rd_chk(OFF_MODE_CTRL, 32'h1040);
      wr_reg(OFF_MODE_CTRL, 32'h11141);
      wr_reg(OFF_IRQ_MASK, 32'h7);
      rd_chk(OFF_MODE_CTRL, 32'h11141);
      rd_chk(OFF_IRQ_MASK, 32'h7);
      // ch0 falls in both-edge mode, ch1 rises in high-level mode
      @(posedge clk_sys);
      want <= 3'h2;
      repeat (3) @(posedge clk_sys);
      #1 chk("req", 32'h2, {29'h0, req});
      chk("irq", 32'h1, {31'h0, irq});
      rd_chk(OFF_MODE_CTRL, 32'h11149);
      rd_chk(OFF_IRQ_STATUS, 32'h3);
      wr_reg(OFF_IRQ_CLEAR, 32'h3);
      rd_chk(OFF_MODE_CTRL, 32'h11141);
      // ch1 level still present, so its status comes back
      rd_chk(OFF_IRQ_STATUS, 32'h2);
      wr_reg(OFF_MODE_CTRL, 32'h4000);
      wr_reg(OFF_MODE_CTRL, 32'h14101);
      // slow source: ch1 falls, then rises
      lag  <= 4'h3;
      want <= 3'h0;
      repeat (6) @(posedge clk_sys);
      want <= 3'h2;
      wait_req(1);
      chk("req0", 32'h1, {31'h0, req[0]});
      rd_chk(OFF_MODE_CTRL, 32'h14D01);
      wr_reg(OFF_IRQ_MASK, 32'h0);
      wr_reg(OFF_IRQ_CLEAR, 32'h7);
      rd_chk(OFF_IRQ_STATUS, 32'h1);
      chk("irq", 32'h0, {31'h0, irq});
      rd_chk(OFF_MODE_CTRL, 32'h14101);
      rd_chk(8'h10, 32'h0);
      // edge modes: ch0 rising, ch1 and ch2 falling; ch1 first held off
      @(posedge clk_sys);
      lag <= 4'h0;
      wr_reg(OFF_MODE_CTRL, 32'h2030);
      @(posedge clk_sys);
      want <= 3'h0;
      @(posedge clk_sys);
      #1 chk("req", 32'h0, {29'h0, req});
      wr_reg(OFF_MODE_CTRL, 32'h12131);
      @(posedge clk_sys);
      want <= 3'h5;
      @(posedge clk_sys);
      want <= 3'h2;
      #1 chk("req", 32'h1, {29'h0, req});
      @(posedge clk_sys);
      want <= 3'h0;
      #1 chk("req", 32'h4, {29'h0, req});
      @(posedge clk_sys);
      #1 chk("req", 32'h2, {29'h0, req});
      rd_chk(OFF_MODE_CTRL, 32'h12131);
      // both-edge mode, a lone rising edge reports 01
      wr_reg(OFF_MODE_CTRL, 32'h4040);
      wr_reg(OFF_MODE_CTRL, 32'h4141);
      @(posedge clk_sys);
      want <= 3'h3;
      rd_chk(OFF_MODE_CTRL, 32'h4545);
      close_out();
   end
endmodule
bind standby_release_trigger_config srel_assertions #(.NUM_CH(NUM_CH)) chk_u (.CLK_SYS, .RSTN, .ADDR, .WDATA,
   .WR, .RD, .RDATA, .EXT_REQUEST_CH0, .EXT_REQUEST_CH1, .EXT_REQUEST_CH2, .RELEASE_REQ, .IRQ);
